// ===== core/pulse_cfg.svh
// Purpose: Offsets, field positions and reset values of the pulse unit
// Assumes: Byte addresses on a 32-bit Wishbone bus, data in bits 7:0
// Notes: Definitions only
`ifndef PULSE_CFG_SVH
`define PULSE_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_EN_LOW 8'h00
`define OFS_EN_HIGH 8'h04
`define OFS_TRIG 8'h08
`define OFS_NV_LOW 8'h0c
`define OFS_NV_HIGH 8'h10
`define OFS_LATCH_A 8'h14
`define OFS_LATCH_B 8'h18
`define OFS_DIR_A 8'h1c
`define OFS_DIR_B 8'h20
`define OFS_ACTIVE_A 8'h24
`define OFS_ACTIVE_B 8'h28

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_EN 8'h00
`define RST_TRIG 8'hff
`define RST_NV 8'h00
`define RST_LATCH 8'h00
`define RST_DIR 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TRIG_G0_LSB 0
`define TRIG_G1_LSB 2
`define TRIG_G2_LSB 4
`define TRIG_G3_LSB 6
`define PIN_B_ABSENT 6
`define PIN_B_MASK 8'hbf

`endif

// ===== core/pulse_pkg.sv
// Purpose: Types shared by the pulse unit files
// Assumes: Nothing
// Notes: Constants live in pulse_cfg.svh
package pulse_pkg;

    // ----------------------------------------
    // Timer channel select
    // ----------------------------------------
    typedef enum logic [1:0] {
        chan0 = 2'b00,
        chan1 = 2'b01,
        chan2 = 2'b10,
        chan3 = 2'b11
    } chan_e;

    // ----------------------------------------
    // Bus request bundle
    // ----------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic sel;
        logic [7:0] dat;
    } wb_req_s;

    // ----------------------------------------
    // Whole state of the unit
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] en_low;
        logic [7:0] en_high;
        logic [7:0] trig;
        logic [7:0] nv_low;
        logic [7:0] nv_high;
        logic [7:0] latch_a;
        logic [7:0] latch_b;
        logic [7:0] dir_a;
        logic [7:0] dir_b;
        logic [7:0] oe_a_n;
        logic [7:0] oe_b_n;
        logic [7:0] pin_b;
        logic ack;
        logic [7:0] rdat;
    } state_s;

endpackage : pulse_pkg

// ===== core/pulse_group.sv
// Purpose: One pulse group: trigger pick and masked next-value transfer
// Assumes: Compare-match strobes are one cycle wide
// Notes: Purely combinational
`timescale 1ns/1ps
module pulse_group
    import pulse_pkg::*;
#(
    parameter int W = 4
) (
    // Trigger
    input wire chan_e sel_i,
    input wire logic [3:0] match_i,
    // Data
    input wire logic [W-1:0] en_i,
    input wire logic [W-1:0] next_i,
    input wire logic [W-1:0] cur_i,
    output logic fire_o,
    output logic [W-1:0] data_o
);

    always_comb begin
        fire_o = match_i[sel_i];
        data_o = cur_i;
        if (fire_o) begin
            data_o = (next_i & en_i) | (cur_i & ~en_i);
        end
    end

endmodule : pulse_group

// ===== core/pulse_pattern_enable_trigger.sv
// Purpose: Per-bit enables and per-group trigger select of a 16-bit pulse unit
// Assumes: Wishbone classic slave, 8-bit registers in data bits 7:0
// Notes: Four groups of four bits, two 8-bit ports
//
// Overview of operation
// - Enable register low: bits 7..0 enable pulse output of port A pins.
// - On selected match, enabled port A bits take their next value.
// - Disabled port A bits keep latch and pin on a match.
// - Low enable clears on reset and hardware standby, kept in software standby.
// - Enable register high: bits map next bits 15..8 onto port B.
// - On selected match, enabled port B bits take their upper next value.
// - Disabled port B bits keep latch and pin on a match.
// - High enable clears on reset and hardware standby, kept in software standby.
// - Trigger select holds four 2-bit channel fields, one per group.
// - Trigger select resets to all ones, channel 3 for every group.
// - Bits 7:6 pick the channel for group 3.
// - Bits 5:4 pick the channel for group 2.
// - Bits 3:2 pick the channel for group 1.
// - Pattern bit 14 never reaches a pin; its latch bit still works.
// - Bits 1:0 pick the channel for group 0, reset value 11.
// - Pulse output needs enable and direction; enabled input latch is read-only.
// - Next-value registers hold data for the next match, one nibble per group.
`timescale 1ns/1ps
`include "pulse_cfg.svh"
module pulse_pattern_enable_trigger
    import pulse_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Standby
    input wire logic hw_standby_i,
    input wire logic sw_standby_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Timer compare-match strobes
    input wire logic [3:0] cmp_match_i,
    // Port A pins
    output logic [7:0] pin_a_o,
    output logic [7:0] pin_a_oe_n_o,
    // Port B pins
    output logic [7:0] pin_b_o,
    output logic [7:0] pin_b_oe_n_o
);

    // ----------------------------------------
    // Reset image
    // ----------------------------------------
    localparam state_s RST_STATE = '{
        en_low: `RST_EN,
        en_high: `RST_EN,
        trig: `RST_TRIG,
        nv_low: `RST_NV,
        nv_high: `RST_NV,
        latch_a: `RST_LATCH,
        latch_b: `RST_LATCH,
        dir_a: `RST_DIR,
        dir_b: `RST_DIR,
        oe_a_n: ~`RST_DIR,
        oe_b_n: ~`RST_DIR,
        pin_b: `RST_LATCH,
        ack: 1'b0,
        rdat: 8'h00
    };

    state_s st_q;
    state_s st_d;
    wb_req_s req;
    logic access;
    logic wr;
    logic [7:0] rd_val;
    logic wr_latch_a;
    logic wr_latch_b;
    logic [7:0] ro_a;
    logic [7:0] ro_b;
    logic [7:0] sw_a;
    logic [7:0] sw_b;
    logic [7:0] xfer_a;
    logic [7:0] xfer_b;
    logic [3:0] fire;

    // ----------------------------------------
    // Bus request
    // ----------------------------------------
    assign req = '{
        cyc: cyc_i,
        stb: stb_i,
        we: we_i,
        adr: adr_i,
        sel: sel_i[0],
        dat: dat_i[7:0]
    };
    assign access = req.cyc & req.stb & ~st_q.ack;
    assign wr = access & req.we & req.sel;
    assign wr_latch_a = wr & (req.adr == `OFS_LATCH_A);
    assign wr_latch_b = wr & (req.adr == `OFS_LATCH_B);

    // ----------------------------------------
    // Software writes to the port latches
    // ----------------------------------------
    // Enabled bits with direction clear are read-only
    assign ro_a = st_q.en_low & ~st_q.dir_a;
    assign ro_b = st_q.en_high & ~st_q.dir_b;
    assign sw_a = wr_latch_a ? ((req.dat & ~ro_a) | (st_q.latch_a & ro_a)) : st_q.latch_a;
    assign sw_b = wr_latch_b ? ((req.dat & ~ro_b) | (st_q.latch_b & ro_b)) : st_q.latch_b;

    // ----------------------------------------
    // Group transfers
    // ----------------------------------------
    // Group 0: port A bits 3:0
    pulse_group #(
        .W(4)
    ) u_grp0 (
        .sel_i(chan_e'(st_q.trig[`TRIG_G0_LSB +: 2])),
        .match_i(cmp_match_i),
        .en_i(st_q.en_low[3:0]),
        .next_i(st_q.nv_low[3:0]),
        .cur_i(sw_a[3:0]),
        .fire_o(fire[0]),
        .data_o(xfer_a[3:0])
    );

    // Group 1: port A bits 7:4
    pulse_group #(
        .W(4)
    ) u_grp1 (
        .sel_i(chan_e'(st_q.trig[`TRIG_G1_LSB +: 2])),
        .match_i(cmp_match_i),
        .en_i(st_q.en_low[7:4]),
        .next_i(st_q.nv_low[7:4]),
        .cur_i(sw_a[7:4]),
        .fire_o(fire[1]),
        .data_o(xfer_a[7:4])
    );

    // Group 2: port B bits 3:0
    pulse_group #(
        .W(4)
    ) u_grp2 (
        .sel_i(chan_e'(st_q.trig[`TRIG_G2_LSB +: 2])),
        .match_i(cmp_match_i),
        .en_i(st_q.en_high[3:0]),
        .next_i(st_q.nv_high[3:0]),
        .cur_i(sw_b[3:0]),
        .fire_o(fire[2]),
        .data_o(xfer_b[3:0])
    );

    // Group 3: port B bits 7:4
    pulse_group #(
        .W(4)
    ) u_grp3 (
        .sel_i(chan_e'(st_q.trig[`TRIG_G3_LSB +: 2])),
        .match_i(cmp_match_i),
        .en_i(st_q.en_high[7:4]),
        .next_i(st_q.nv_high[7:4]),
        .cur_i(sw_b[7:4]),
        .fire_o(fire[3]),
        .data_o(xfer_b[7:4])
    );

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        rd_val = 8'h00;
        case (req.adr)
            `OFS_EN_LOW: rd_val = st_q.en_low;
            `OFS_EN_HIGH: rd_val = st_q.en_high;
            `OFS_TRIG: rd_val = st_q.trig;
            `OFS_NV_LOW: rd_val = st_q.nv_low;
            `OFS_NV_HIGH: rd_val = st_q.nv_high;
            `OFS_LATCH_A: rd_val = st_q.latch_a;
            `OFS_LATCH_B: rd_val = st_q.latch_b;
            `OFS_DIR_A: rd_val = st_q.dir_a;
            `OFS_DIR_B: rd_val = st_q.dir_b;
            `OFS_ACTIVE_A: rd_val = st_q.en_low & st_q.dir_a;
            `OFS_ACTIVE_B: rd_val = st_q.en_high & st_q.dir_b;
            default: rd_val = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.ack = access;
        if (access) begin
            st_d.rdat = rd_val;
        end
        if (wr) begin
            case (req.adr)
                `OFS_EN_LOW: st_d.en_low = req.dat;
                `OFS_EN_HIGH: st_d.en_high = req.dat;
                `OFS_TRIG: st_d.trig = req.dat;
                `OFS_NV_LOW: st_d.nv_low = req.dat;
                `OFS_NV_HIGH: st_d.nv_high = req.dat;
                `OFS_DIR_A: st_d.dir_a = req.dat;
                `OFS_DIR_B: st_d.dir_b = req.dat;
                default: st_d.rdat = st_d.rdat;
            endcase
        end
        // Transfer on a match wins over a software write
        st_d.latch_a = xfer_a;
        st_d.latch_b = xfer_b;
        // Pin drive follows latch and direction; port B bit 6 (pattern bit 14) is never driven
        st_d.oe_a_n = ~st_d.dir_a;
        st_d.oe_b_n = ~st_d.dir_b | ~`PIN_B_MASK;
        st_d.pin_b = st_d.latch_b & `PIN_B_MASK;
        // Software standby keeps every register
        if (rst_i | hw_standby_i) begin
            st_d = RST_STATE;
        end
    end

    always_ff @(posedge clk_i) begin
        st_q <= st_d;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign ack_o = st_q.ack;
    assign dat_o = {24'h000000, st_q.rdat};
    assign pin_a_o = st_q.latch_a;
    assign pin_a_oe_n_o = st_q.oe_a_n;
    assign pin_b_o = st_q.pin_b;
    assign pin_b_oe_n_o = st_q.oe_b_n;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_en_low_standby:
    assert property (hw_standby_i |=> st_q.en_low == 8'h00 && pin_a_oe_n_o == 8'hff)
    else $error("low enable not cleared by hardware standby");

    a_en_high_standby:
    assert property (hw_standby_i |=> st_q.en_high == 8'h00 && pin_b_o == 8'h00)
    else $error("high enable not cleared by hardware standby");

    a_trig_standby:
    assert property (hw_standby_i |=> st_q.trig == 8'hff)
    else $error("trigger select not all ones after hardware standby");

    a_swsb_keeps:
    assert property (sw_standby_i && !hw_standby_i && !cyc_i |=> $stable(st_q.en_low)
        && $stable(st_q.en_high) && $stable(st_q.trig))
    else $error("registers lost in software standby");

    a_grp0_copy:
    assert property (!hw_standby_i && cmp_match_i[st_q.trig[1:0]]
        |=> ((pin_a_o ^ $past(st_q.nv_low)) & $past(st_q.en_low) & 8'h0f) == 8'h00)
    else $error("group 0 enabled bits not loaded on match");

    a_port_a_hold:
    assert property (!hw_standby_i && !wr_latch_a
        |=> ((pin_a_o ^ $past(pin_a_o)) & ~$past(st_q.en_low)) == 8'h00)
    else $error("disabled port A bit changed");

    a_grp3_copy:
    assert property (!hw_standby_i && cmp_match_i[st_q.trig[7:6]] && st_q.en_high[7]
        |=> st_q.latch_b[7] == $past(st_q.nv_high[7]))
    else $error("group 3 bit 7 not loaded from its channel");

    a_grp2_copy:
    assert property (!hw_standby_i && cmp_match_i[st_q.trig[5:4]]
        |=> ((st_q.latch_b ^ $past(st_q.nv_high)) & $past(st_q.en_high) & 8'h0f) == 8'h00)
    else $error("group 2 enabled bits not loaded on match");

    a_port_b_hold:
    assert property (!hw_standby_i && !wr_latch_b
        |=> ((st_q.latch_b ^ $past(st_q.latch_b)) & ~$past(st_q.en_high)) == 8'h00)
    else $error("disabled port B bit changed");

    a_bit14_quiet:
    assert property (pin_b_oe_n_o[`PIN_B_ABSENT] && !pin_b_o[`PIN_B_ABSENT])
    else $error("absent pattern bit 14 driven");

    a_no_match_idle:
    assert property (cmp_match_i == 4'h0 && !hw_standby_i && !cyc_i
        |=> $stable(st_q.latch_a) && $stable(st_q.latch_b))
    else $error("latch moved without match or write");

    a_ro_latch:
    assert property (wr_latch_a && !hw_standby_i && cmp_match_i == 4'h0
        |=> ((st_q.latch_a ^ $past(st_q.latch_a)) & $past(ro_a)) == 8'h00)
    else $error("read-only port A bit written by software");

    a_bus_ack:
    assert property (cyc_i && stb_i && !ack_o && !hw_standby_i ##1 !hw_standby_i
        |-> ack_o ##1 !ack_o)
    else $error("bus answer not one cycle long");

    a_grp1_copy:
    assert property (!hw_standby_i && cmp_match_i[st_q.trig[3:2]]
        |=> ((pin_a_o ^ $past(st_q.nv_low)) & $past(st_q.en_low) & 8'hf0) == 8'h00)
    else $error("group 1 enabled bits not loaded on match");

    a_grp0_other:
    assert property (!hw_standby_i && !cmp_match_i[st_q.trig[1:0]] && !wr_latch_a
        |=> pin_a_o[3:0] == $past(pin_a_o[3:0]))
    else $error("group 0 loaded by a channel it did not select");

    a_grp1_other:
    assert property (!hw_standby_i && !cmp_match_i[st_q.trig[3:2]] && !wr_latch_a
        |=> pin_a_o[7:4] == $past(pin_a_o[7:4]))
    else $error("group 1 loaded by a channel it did not select");

    a_grp2_other:
    assert property (!hw_standby_i && !cmp_match_i[st_q.trig[5:4]] && !wr_latch_b
        |=> st_q.latch_b[3:0] == $past(st_q.latch_b[3:0]))
    else $error("group 2 loaded by a channel it did not select");

    a_grp3_other:
    assert property (!hw_standby_i && !cmp_match_i[st_q.trig[7:6]] && !wr_latch_b
        |=> st_q.latch_b[7:4] == $past(st_q.latch_b[7:4]))
    else $error("group 3 loaded by a channel it did not select");

    a_fire_load:
    assert property (fire[0] && !hw_standby_i && st_q.en_low[0]
        |=> pin_a_o[0] == $past(st_q.nv_low[0]))
    else $error("group 0 strobe did not load its latch bit");

    a_oe_a_dir:
    assert property (pin_a_oe_n_o == ~st_q.dir_a)
    else $error("port A drive does not follow direction");

    a_oe_b_dir:
    assert property (pin_b_oe_n_o == (~st_q.dir_b | 8'h40))
    else $error("port B drive does not follow direction");

    a_pin_b_mask:
    assert property (pin_b_o == (st_q.latch_b & 8'hbf))
    else $error("port B pins do not follow the latch");

endmodule : pulse_pattern_enable_trigger

// ===== bench/timer_model.sv
// Purpose: Timer stand-in that issues compare-match strobes
// Assumes: One request cycle gives one strobe cycle
// Notes: slow_i delays every strobe by one extra cycle
`timescale 1ns/1ps
module timer_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic [3:0] req_i,
    input wire logic slow_i,
    // Strobes
    output logic [3:0] cmp_match_o
);
    logic [3:0] dly_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dly_q <= 4'h0;
            cmp_match_o <= 4'h0;
        end else begin
            dly_q <= req_i;
            cmp_match_o <= slow_i ? dly_q : req_i;
        end
    end
endmodule : timer_model

// ===== bench/pulse_pattern_enable_trigger_bench.sv
// Purpose: Self-checking bench of the pulse enable and trigger unit
// Assumes: Registered one-cycle ack, transfer on the strobe edge
// Notes: Random setups from an LFSR seeded with 58224
`timescale 1ns/1ps
`include "pulse_cfg.svh"
module pulse_pattern_enable_trigger_bench;
    import pulse_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hw_standby_i = 1'b0;
    logic sw_standby_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [3:0] wsel = 4'hf;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic [3:0] cmp_match_i;
    logic [3:0] req_q = 4'h0;
    logic slow_q = 1'b0;
    logic [7:0] pin_a_o, pin_a_oe_n_o, pin_b_o, pin_b_oe_n_o;
    logic [15:0] lfsr_q = 16'he370;
    logic [7:0] rd;
    int err_total = 0;
    int check_count = 0;
    int ea, eb, tr, na, nb, la, lb, da, db;
    always #12.5 clk_i = ~clk_i;
    timer_model timer_model_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_q), .slow_i(slow_q),
        .cmp_match_o(cmp_match_i));
    pulse_pattern_enable_trigger pulse_pattern_enable_trigger_i (.clk_i(clk_i), .rst_i(rst_i),
        .hw_standby_i(hw_standby_i), .sw_standby_i(sw_standby_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .cmp_match_i(cmp_match_i), .pin_a_o(pin_a_o), .pin_a_oe_n_o(pin_a_oe_n_o),
        .pin_b_o(pin_b_o), .pin_b_oe_n_o(pin_b_oe_n_o));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [7:0] rnd();
        lfsr_q = {1'b0, lfsr_q[15:1]} ^ (lfsr_q[0] ? 16'hb400 : 16'h0000);
        return lfsr_q[7:0];
    endfunction : rnd
    task automatic give_verdict();
        if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= wsel;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) err_total++;
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic rchk(input string what, input logic [7:0] a, input int exp);
        wb(1'b0, a, 8'h00);
        chk(what, exp[7:0], rd);
    endtask : rchk
    task automatic fire(input logic [7:0] m);
        int ch, msk;
        req_q <= m[3:0];
        @(posedge clk_i);
        req_q <= 4'h0;
        repeat (3) @(posedge clk_i);
        for (int g = 0; g < 4; g++) begin
            ch = (tr >> (2 * g)) & 3;
            msk = 15 << (4 * (g % 2));
            if (m[ch] && g < 2) la = (la & ~(ea & msk)) | (na & ea & msk);
            if (m[ch] && g >= 2) lb = (lb & ~(eb & msk)) | (nb & eb & msk);
        end
    endtask : fire
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rchk("en_low rst", `OFS_EN_LOW, 0);
        rchk("en_high rst", `OFS_EN_HIGH, 0);
        rchk("trig rst", `OFS_TRIG, 255);
        rchk("unmapped", 8'h30, 0);
        chk("oe_b rst", 8'hff, pin_b_oe_n_o);
        la = 0;
        lb = 0;
        for (int i = 0; i < 60; i++) begin
            ea = rnd();
            eb = rnd();
            tr = rnd();
            na = rnd();
            nb = rnd();
            da = rnd();
            db = rnd();
            sw_standby_i <= rnd() > 8'h80;
            slow_q <= rnd() > 8'h80;
            wb(1'b1, `OFS_EN_LOW, ea[7:0]);
            wb(1'b1, `OFS_EN_HIGH, eb[7:0]);
            wb(1'b1, `OFS_TRIG, tr[7:0]);
            wb(1'b1, `OFS_NV_LOW, na[7:0]);
            wb(1'b1, `OFS_NV_HIGH, nb[7:0]);
            wb(1'b1, `OFS_DIR_A, da[7:0]);
            wb(1'b1, `OFS_DIR_B, db[7:0]);
            ch_latch: begin
                int wa, wbv;
                wa = rnd();
                wbv = rnd();
                wb(1'b1, `OFS_LATCH_A, wa[7:0]);
                wb(1'b1, `OFS_LATCH_B, wbv[7:0]);
                la = (la & ea & ~da) | (wa & ~(ea & ~da));
                lb = (lb & eb & ~db) | (wbv & ~(eb & ~db));
            end
            rchk("en_low", `OFS_EN_LOW, ea);
            rchk("en_high", `OFS_EN_HIGH, eb);
            rchk("trig", `OFS_TRIG, tr);
            rchk("active_a", `OFS_ACTIVE_A, ea & da);
            rchk("latch_a sw", `OFS_LATCH_A, la);
            rchk("active_b", `OFS_ACTIVE_B, eb & db);
            rchk("nv_low", `OFS_NV_LOW, na);
            rchk("nv_high", `OFS_NV_HIGH, nb);
            fire(rnd() & 8'h0f);
            chk("pin_a", la[7:0], pin_a_o);
            chk("pin_b", lb[7:0] & 8'hbf, pin_b_o);
            chk("oe_a", ~da[7:0], pin_a_oe_n_o);
            chk("oe_b", ~db[7:0] | 8'h40, pin_b_oe_n_o);
            rchk("latch_b", `OFS_LATCH_B, lb);
        end
        rchk("en_low kept", `OFS_EN_LOW, ea);
        wsel = 4'he;
        wb(1'b1, `OFS_EN_LOW, ~ea[7:0]);
        wsel = 4'hf;
        rchk("en_low sel0", `OFS_EN_LOW, ea);
        hw_standby_i <= 1'b1;
        @(posedge clk_i);
        hw_standby_i <= 1'b0;
        @(posedge clk_i);
        rchk("en_low hw", `OFS_EN_LOW, 0);
        rchk("en_high hw", `OFS_EN_HIGH, 0);
        rchk("trig hw", `OFS_TRIG, 255);
        give_verdict();
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        err_total++;
        give_verdict();
    end
endmodule : pulse_pattern_enable_trigger_bench
